// ==== fsps_top.sv ====
// Function
// - Signature request plus enable, then load within three cycles, returns row byte.
// - Signature request and enable self-clear after the read or three idle cycles.
// - With both bits clear, loads read the flash normally.
// - Z 0x0000, 0x0002, 0x0004 return identity bytes one, two, three.
// - Z 0x0001 returns the oscillator calibration byte.
// - A reset during a flash write lets the write finish.
// - Erase, write and lock write last between 3.7 ms and 4.5 ms.
// - Boot size 11 gives start 0x7E00, 10 gives 0x7C00; ends 0x7FFF.
// - Boot size 01 gives start 0x7800, 00 gives 0x7000.
// - Words 0x0000 to 0x6FFF read while writing; top 32 pages do not.
// - Program counter is 15 bits; pages hold 128 words.
// - Erase and write take the page from the Z high bits.
// - Z7:Z1 index the page buffer; software keeps them zero on write.
// - Z0 is zero for stores and selects the byte for loads.
// - A store within four cycles of a signature request does nothing.
// - Busy flag sets on lower-section erase or write, clears on re-enable or load.
// - Control bits: 5 signature, 6 busy, 4 re-enable, 0 enable; reset zero.
`timescale 1ns/1ps
`default_nettype none

module fsps_top #(
  parameter int            OP_CYCLES = fsps_pkg::OP_MIN_CYCLES,
  parameter logic [7:0]    ID_BYTE1  = 8'h11, // Arbitrary value.
  parameter logic [7:0]    ID_BYTE2  = 8'h22, // Arbitrary value.
  parameter logic [7:0]    ID_BYTE3  = 8'h33  // Arbitrary value.
) (
  input  wire logic                      clk,           // 50 MHz clock.
  input  wire logic                      nrst,          // Sync reset.
  input  wire logic                      psel,          // APB select.
  input  wire logic                      penable,       // APB enable.
  input  wire logic                      pwrite,        // APB direction.
  input  wire logic [31:0]               paddr,         // APB address.
  input  wire logic [31:0]               pwdata,        // APB write data.
  output logic      [31:0]               prdata,        // APB read data.
  output logic                           pready,        // APB ready.
  output logic                           pslverr,       // APB error.
  input  wire fsps_pkg::fsps_cpu_req_t   cpu_req,       // CPU load/store.
  input  wire logic [15:0]               flash_word,    // Word at Z[15:1].
  input  wire logic [7:0]                osc_cal_byte,  // Calibration.
  input  wire logic                      eeprom_write_busy, // EEPROM busy.
  input  wire logic                      boot_size_hi,  // Fuse pin.
  input  wire logic                      boot_size_lo,  // Fuse pin.
  output logic      [7:0]                load_data,     // Load result.
  output logic                           load_valid,    // Load strobe.
  output fsps_pkg::fsps_flash_cmd_t      flash_cmd,     // Flash command.
  output logic                           fetch_stall,   // Halt fetch.
  output logic                           rww_section_busy, // Lower busy.
  output logic      [14:0]               boot_start     // Boot start word.
);

  fsps_pkg::fsps_state_t     st_ff;
  fsps_pkg::fsps_flash_cmd_t flash_cmd_ff;
  logic [7:0]  prog_store_ctrl_reg_ff;
  logic [2:0]  win_ff;
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic [7:0]  load_data_ff;
  logic        load_valid_ff;
  logic        stall_ff;
  logic [14:0] boot_start_ff;
  logic [1:0]  fuse_s1_ff;
  logic [1:0]  fuse_s2_ff;
  logic        apb_done;
  logic        ctrl_wr;
  logic        sig_armed;
  logic        tmr_start;
  logic        tmr_busy;
  logic        tmr_done;
  logic        tmr_upper;
  logic [7:0]  z_page;
  logic [5:0]  wr_cmd;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function automatic logic page_in_upper(input logic [7:0] page);
    page_in_upper = (page > fsps_pkg::LOWER_LAST_PAGE);
  endfunction

  function automatic logic [14:0] boot_start_of(input logic [1:0] fuse);
    case (fuse)
      2'b11:   boot_start_of = fsps_pkg::BOOT_START_11;
      2'b10:   boot_start_of = fsps_pkg::BOOT_START_10;
      2'b01:   boot_start_of = fsps_pkg::BOOT_START_01;
      default: boot_start_of = fsps_pkg::BOOT_START_00;
    endcase
  endfunction

  function automatic logic [7:0] sig_byte(input logic [15:0] z,
                                          input logic [7:0]  cal);
    if (z == fsps_pkg::SIG_Z_ID1) begin
      sig_byte = ID_BYTE1;
    end else if (z == fsps_pkg::SIG_Z_ID2) begin
      sig_byte = ID_BYTE2;
    end else if (z == fsps_pkg::SIG_Z_ID3) begin
      sig_byte = ID_BYTE3;
    end else if (z == fsps_pkg::SIG_Z_CAL) begin
      sig_byte = cal;
    end else begin
      sig_byte = fsps_pkg::SIG_RSVD;
    end
  endfunction

  function automatic logic cmd_legal(input logic [5:0] c);
    cmd_legal = (c == fsps_pkg::CMD_SIG)   || (c == fsps_pkg::CMD_REEN) ||
                (c == fsps_pkg::CMD_LOCK)  || (c == fsps_pkg::CMD_WRITE) ||
                (c == fsps_pkg::CMD_ERASE) || (c == fsps_pkg::CMD_LOAD);
  endfunction

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  // Every access has exactly one wait state; the transfer completes on
  // the edge where the registered ready is seen high.
  assign apb_done  = psel && penable && pready_ff;
  assign ctrl_wr   = apb_done && pwrite && (paddr == fsps_pkg::CTRL_ADDR);
  assign wr_cmd    = pwdata[5:0];
  assign z_page    = cpu_req.z[15:8];
  assign sig_armed = (st_ff == fsps_pkg::FSPS_ARMED) &&
                     prog_store_ctrl_reg_ff[fsps_pkg::BIT_SIG_REQ];

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h00000000;
    end else begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= 1'b0;
      if (psel && penable && !pready_ff) begin
        if (paddr == fsps_pkg::CTRL_ADDR) begin
          prdata_ff <= {24'h000000, prog_store_ctrl_reg_ff[7:1],
                        prog_store_ctrl_reg_ff[0] | tmr_busy};
        end else if (paddr == fsps_pkg::STATUS_ADDR) begin
          prdata_ff <= {13'h0000, fuse_s2_ff, boot_start_ff,
                        stall_ff, tmr_busy};
        end else begin
          prdata_ff  <= 32'h00000000;
          pslverr_ff <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Boot size fuse synchroniser and decode
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      fuse_s1_ff    <= 2'b00;
      fuse_s2_ff    <= 2'b00;
      boot_start_ff <= fsps_pkg::BOOT_START_00;
    end else begin
      fuse_s1_ff    <= {boot_size_hi, boot_size_lo};
      fuse_s2_ff    <= fuse_s1_ff;
      boot_start_ff <= boot_start_of(fuse_s2_ff);
    end
  end

  // ----------------------------------------------------------------------
  // Control register and command sequencer
  // ----------------------------------------------------------------------
  assign tmr_start = (st_ff == fsps_pkg::FSPS_ARMED) && cpu_req.spm &&
                     !prog_store_ctrl_reg_ff[fsps_pkg::BIT_SIG_REQ] &&
                     (prog_store_ctrl_reg_ff[fsps_pkg::BIT_PGERS] ||
                      prog_store_ctrl_reg_ff[fsps_pkg::BIT_PGWRT] ||
                      prog_store_ctrl_reg_ff[fsps_pkg::BIT_BLBSET]);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff                  <= fsps_pkg::FSPS_IDLE;
      prog_store_ctrl_reg_ff <= fsps_pkg::CTRL_RESET;
      win_ff                 <= 3'h0;
    end else begin
      case (st_ff)
        fsps_pkg::FSPS_IDLE: begin
          if (ctrl_wr) begin
            prog_store_ctrl_reg_ff[fsps_pkg::BIT_SPMIE] <=
              pwdata[fsps_pkg::BIT_SPMIE];
          end
          if (ctrl_wr && !eeprom_write_busy && !tmr_busy &&
              cmd_legal(wr_cmd)) begin
            prog_store_ctrl_reg_ff[5:0] <= wr_cmd;
            st_ff  <= fsps_pkg::FSPS_ARMED;
            win_ff <= (wr_cmd == fsps_pkg::CMD_SIG) ?
                      3'(fsps_pkg::LOAD_WINDOW) : 3'(fsps_pkg::SPM_WINDOW);
          end
        end
        fsps_pkg::FSPS_ARMED: begin
          win_ff <= win_ff - 3'h1;
          if (prog_store_ctrl_reg_ff[fsps_pkg::BIT_SIG_REQ]) begin
            if (cpu_req.mem_load || win_ff == 3'h1) begin
              prog_store_ctrl_reg_ff[5:0] <= 6'h00;
              st_ff <= fsps_pkg::FSPS_IDLE;
            end
          end else if (tmr_start) begin
            st_ff <= fsps_pkg::FSPS_TIMED;
            if (!prog_store_ctrl_reg_ff[fsps_pkg::BIT_BLBSET] &&
                !page_in_upper(z_page)) begin
              prog_store_ctrl_reg_ff[fsps_pkg::BIT_SEC_BUSY] <= 1'b1;
            end
          end else if (cpu_req.spm) begin
            if (!prog_store_ctrl_reg_ff[fsps_pkg::BIT_SEC_REEN] ||
                !tmr_busy) begin
              prog_store_ctrl_reg_ff[fsps_pkg::BIT_SEC_BUSY] <= 1'b0;
            end
            prog_store_ctrl_reg_ff[5:0] <= 6'h00;
            st_ff <= fsps_pkg::FSPS_IDLE;
          end else if (win_ff == 3'h1) begin
            prog_store_ctrl_reg_ff[5:0] <= 6'h00;
            st_ff <= fsps_pkg::FSPS_IDLE;
          end
        end
        fsps_pkg::FSPS_TIMED: begin
          if (tmr_done) begin
            prog_store_ctrl_reg_ff[5:0] <= 6'h00;
            st_ff <= fsps_pkg::FSPS_IDLE;
          end
        end
        default: begin
          st_ff <= fsps_pkg::FSPS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Flash command pulses
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flash_cmd_ff <= '0;
    end else begin
      flash_cmd_ff       <= '0;
      flash_cmd_ff.page  <= z_page;
      flash_cmd_ff.word  <= cpu_req.z[7:1];
      flash_cmd_ff.data  <= cpu_req.data;
      if (st_ff == fsps_pkg::FSPS_ARMED && cpu_req.spm &&
          !prog_store_ctrl_reg_ff[fsps_pkg::BIT_SIG_REQ]) begin
        case (prog_store_ctrl_reg_ff[5:0])
          fsps_pkg::CMD_ERASE: flash_cmd_ff.erase <= 1'b1;
          fsps_pkg::CMD_WRITE: flash_cmd_ff.write <= 1'b1;
          fsps_pkg::CMD_LOCK:  flash_cmd_ff.lock  <= 1'b1;
          fsps_pkg::CMD_LOAD:  flash_cmd_ff.load  <= 1'b1;
          fsps_pkg::CMD_REEN:  flash_cmd_ff.clear_buf <= !tmr_busy;
          default:             flash_cmd_ff.load  <= 1'b0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Program memory load path
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      load_data_ff  <= 8'h00;
      load_valid_ff <= 1'b0;
    end else begin
      load_valid_ff <= cpu_req.mem_load;
      if (cpu_req.mem_load && sig_armed) begin
        load_data_ff <= sig_byte(cpu_req.z, osc_cal_byte);
      end else if (cpu_req.mem_load) begin
        load_data_ff <= cpu_req.z[0] ? flash_word[15:8]
                                    : flash_word[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Timed operation and fetch stall
  // ----------------------------------------------------------------------
  fsps_timer #(
    .OP_CYCLES (OP_CYCLES)
  ) u_timer (
    .clk        (clk),
    .nrst       (nrst),
    .start      (tmr_start),
    .upper_in   (page_in_upper(z_page) &&
                 !prog_store_ctrl_reg_ff[fsps_pkg::BIT_BLBSET]),
    .busy       (tmr_busy),
    .done       (tmr_done),
    .upper_hold (tmr_upper)
  );

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stall_ff <= 1'b0;
    end else begin
      stall_ff <= (tmr_start && page_in_upper(z_page) &&
                   !prog_store_ctrl_reg_ff[fsps_pkg::BIT_BLBSET]) ||
                  (tmr_busy && tmr_upper && !tmr_done);
    end
  end

  assign prdata           = prdata_ff;
  assign pready           = pready_ff;
  assign pslverr          = pslverr_ff;
  assign load_data        = load_data_ff;
  assign load_valid       = load_valid_ff;
  assign flash_cmd        = flash_cmd_ff;
  assign fetch_stall      = stall_ff;
  assign rww_section_busy = prog_store_ctrl_reg_ff[fsps_pkg::BIT_SEC_BUSY];
  assign boot_start       = boot_start_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_SIG_TIMEOUT: assert property (@(posedge clk) disable iff (!nrst)
    $rose(sig_armed) ##0 (!cpu_req.mem_load) [*3] |=>
      !prog_store_ctrl_reg_ff[fsps_pkg::BIT_STORE_EN])
    else $error("Signature request did not time out.");

  AST_SIG_ID1: assert property (@(posedge clk) disable iff (!nrst)
    cpu_req.mem_load && sig_armed && cpu_req.z == 16'h0000 |=>
      load_data_ff == ID_BYTE1 && load_valid_ff)
    else $error("Wrong identity byte one.");

  AST_SIG_CAL: assert property (@(posedge clk) disable iff (!nrst)
    cpu_req.mem_load && sig_armed && cpu_req.z == 16'h0001 |=>
      load_data_ff == $past(osc_cal_byte))
    else $error("Wrong calibration byte.");

  AST_SIG_AUTOCLR: assert property (@(posedge clk) disable iff (!nrst)
    cpu_req.mem_load && sig_armed |=>
      st_ff == fsps_pkg::FSPS_IDLE &&
      !prog_store_ctrl_reg_ff[fsps_pkg::BIT_SIG_REQ])
    else $error("Signature bits not cleared after read.");

  AST_NORMAL_LOAD: assert property (@(posedge clk) disable iff (!nrst)
    cpu_req.mem_load && !sig_armed && cpu_req.z[0] |=>
      load_data_ff == $past(flash_word[15:8]))
    else $error("Normal load returned wrong byte.");

  AST_SPM_IGNORED: assert property (@(posedge clk) disable iff (!nrst)
    cpu_req.spm && sig_armed |=>
      !flash_cmd_ff.erase && !flash_cmd_ff.write && !flash_cmd_ff.load)
    else $error("Store acted during signature request.");

  AST_ENABLE_HELD: assert property (@(posedge clk) disable iff (!nrst)
    tmr_busy && st_ff == fsps_pkg::FSPS_TIMED |->
      prog_store_ctrl_reg_ff[fsps_pkg::BIT_STORE_EN])
    else $error("Enable dropped during timed operation.");

  AST_BUSY_SET: assert property (@(posedge clk) disable iff (!nrst)
    tmr_start && !page_in_upper(z_page) &&
    !prog_store_ctrl_reg_ff[fsps_pkg::BIT_BLBSET] |=>
      rww_section_busy [*2])
    else $error("Section busy flag not set.");

  AST_STALL: assert property (@(posedge clk) disable iff (!nrst)
    nrst && tmr_busy && tmr_upper && !tmr_done |=> fetch_stall)
    else $error("Fetch not stalled for upper section.");

endmodule

`default_nettype wire

// ==== fsps_pkg.sv ====
package fsps_pkg;

  // ----------------------------------------------------------------------
  // Clock and flash operation timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int OP_MIN_NS     = 3_700_000;
  localparam int OP_MAX_NS     = 4_500_000;
  // Least time rounds up, longest time rounds down.
  localparam int OP_MIN_CYCLES = (OP_MIN_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int OP_MAX_CYCLES = OP_MAX_NS / CLK_PERIOD_NS;
  localparam int LOAD_WINDOW   = 3;
  localparam int SPM_WINDOW    = 4;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CTRL_INDEX   = 8'h37;
  localparam logic [7:0]  STATUS_INDEX = 8'h38;
  localparam logic [31:0] CTRL_ADDR    = {22'h000000, CTRL_INDEX, 2'h0};
  localparam logic [31:0] STATUS_ADDR  = {22'h000000, STATUS_INDEX, 2'h0};
  localparam logic [7:0]  CTRL_RESET   = 8'h00;

  localparam int BIT_SPMIE  = 7;
  localparam int BIT_SEC_BUSY = 6;
  localparam int BIT_SIG_REQ  = 5;
  localparam int BIT_SEC_REEN = 4;
  localparam int BIT_BLBSET = 3;
  localparam int BIT_PGWRT  = 2;
  localparam int BIT_PGERS  = 1;
  localparam int BIT_STORE_EN = 0;

  // Legal values of control bits 5..0 on a command write.
  localparam logic [5:0] CMD_SIG    = 6'h21;
  localparam logic [5:0] CMD_REEN   = 6'h11;
  localparam logic [5:0] CMD_LOCK   = 6'h09;
  localparam logic [5:0] CMD_WRITE  = 6'h05;
  localparam logic [5:0] CMD_ERASE  = 6'h03;
  localparam logic [5:0] CMD_LOAD   = 6'h01;

  // ----------------------------------------------------------------------
  // Signature row and flash geometry
  // ----------------------------------------------------------------------
  localparam logic [15:0] SIG_Z_ID1   = 16'h0000;
  localparam logic [15:0] SIG_Z_CAL   = 16'h0001;
  localparam logic [15:0] SIG_Z_ID2   = 16'h0002;
  localparam logic [15:0] SIG_Z_ID3   = 16'h0004;
  localparam logic [7:0]  SIG_RSVD    = 8'hff;
  localparam int          COUNTER_TOP_BIT   = 14;
  localparam int          PAGE_WORD_TOP_BIT = 7;
  localparam logic [7:0]  LOWER_LAST_PAGE   = 8'hdf;
  localparam logic [14:0] BOOT_START_11     = 15'h7e00;
  localparam logic [14:0] BOOT_START_10     = 15'h7c00;
  localparam logic [14:0] BOOT_START_01     = 15'h7800;
  localparam logic [14:0] BOOT_START_00     = 15'h7000;

  typedef enum logic [1:0] {
    FSPS_IDLE  = 2'b00,
    FSPS_ARMED = 2'b01,
    FSPS_TIMED = 2'b11
  } fsps_state_t;

  typedef struct packed {
    logic        mem_load;
    logic        spm;
    logic [15:0] z;
    logic [15:0] data;
  } fsps_cpu_req_t;

  typedef struct packed {
    logic        erase;
    logic        write;
    logic        lock;
    logic        load;
    logic        clear_buf;
    logic [7:0]  page;
    logic [6:0]  word;
    logic [15:0] data;
  } fsps_flash_cmd_t;

endpackage

// ==== fsps_timer.sv ====
`timescale 1ns/1ps
`default_nettype none

module fsps_timer #(
  parameter int OP_CYCLES = fsps_pkg::OP_MIN_CYCLES
) (
  input  wire logic clk,       // System clock.
  input  wire logic nrst,      // Synchronous reset, active low.
  input  wire logic start,     // Starts a timed flash operation.
  input  wire logic upper_in,   // Target page lies in the upper section.
  output logic      busy,       // Operation in progress.
  output logic      done,       // One-cycle pulse at completion.
  output logic      upper_hold  // Target section of the running operation.
);

  logic [17:0] cnt_ff;
  logic        busy_ff;
  logic        done_ff;
  logic        upper_ff;

  // ----------------------------------------------------------------------
  // Interval counter
  // ----------------------------------------------------------------------
  // A running operation ignores reset so that the flash cell is not left
  // half programmed. Busy is tested first so that an unknown power-up
  // state still falls through to the reset branch.
  always_ff @(posedge clk) begin
    if (busy_ff) begin
      if (cnt_ff == 18'(OP_CYCLES - 1)) begin
        busy_ff <= 1'b0;
        cnt_ff  <= 18'h00000;
      end else begin
        cnt_ff <= cnt_ff + 18'h00001;
      end
    end else if (!nrst) begin
      cnt_ff   <= 18'h00000;
      busy_ff  <= 1'b0;
      upper_ff <= 1'b0;
    end else if (start) begin
      busy_ff  <= 1'b1;
      cnt_ff   <= 18'h00000;
      upper_ff <= upper_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= busy_ff && (cnt_ff == 18'(OP_CYCLES - 1));
    end
  end

  assign busy      = busy_ff;
  assign done      = done_ff;
  assign upper_hold = upper_ff;

  AST_OP_LENGTH: assert property (@(posedge clk)
    $rose(busy_ff) |-> busy_ff [*8])
    else $error("Timed flash operation ended too early.");

endmodule

`default_nettype wire

// ==== fsps_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module fsps_cpu_model (
  input  wire logic              clk,        // System clock.
  output fsps_pkg::fsps_cpu_req_t req,       // Load and store requests.
  output logic [15:0]            flash_word  // Flash word at the Z pointer.
);
  // Flash contents are a fixed pattern of the word address.
  assign flash_word = {req.z[15:1], 1'b0} ^ 16'h5a3c;
  initial req = '0;
  // One load or store, held for exactly one sampling edge.
  task automatic issue(input logic ld, input logic [15:0] z,
                       input logic [15:0] d);
    req.mem_load <= ld;
    req.spm <= ~ld;
    req.z <= z;
    req.data <= d;
    @(posedge clk);
    req.mem_load <= 1'b0;
    req.spm <= 1'b0;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int          OPC  = 20;
  localparam logic [31:0] CTRL = fsps_pkg::CTRL_ADDR;
  localparam logic [7:0]  ID1 = 8'ha1, ID2 = 8'hb2, ID3 = 8'hc3; // Arbitrary.
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, eebusy = 1'b0, bhi = 1'b0, blo = 1'b0;
  logic        pready, pslverr, load_valid, fetch_stall, sec_busy, err;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [7:0]  load_data, cal = 8'h5c;
  logic [14:0] boot_start;
  logic [15:0] flash_word, w;
  logic [15:0] za [4] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004};
  logic [7:0]  sx [4] = '{ID1, 8'h5c, ID2, ID3};
  logic [14:0] bs [4] = '{15'h7000, 15'h7800, 15'h7c00, 15'h7e00};
  int          num_errors = 0, total_checks = 0, n;
  fsps_pkg::fsps_cpu_req_t   cpu_req;
  fsps_pkg::fsps_flash_cmd_t flash_cmd;

  always #10 clk = ~clk;

  fsps_cpu_model cpu (.clk(clk), .req(cpu_req), .flash_word(flash_word));
  fsps_top #(.OP_CYCLES(OPC), .ID_BYTE1(ID1), .ID_BYTE2(ID2),
    .ID_BYTE3(ID3)) dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_req(cpu_req), .flash_word(flash_word), .osc_cal_byte(cal),
    .eeprom_write_busy(eebusy), .boot_size_hi(bhi), .boot_size_lo(blo),
    .load_data(load_data), .load_valid(load_valid), .flash_cmd(flash_cmd),
    .fetch_stall(fetch_stall), .rww_section_busy(sec_busy),
    .boot_start(boot_start));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; one idle edge after it keeps drives apart.
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task cmd(input logic [5:0] c, input logic ld, input logic [15:0] z);
    apb(1'b1, CTRL, {26'h0, c});
    cpu.issue(ld, z, 16'hbeef);
  endtask
  task wait_idle;
    n = 0;
    do begin
      apb(1'b0, CTRL, '0);
      n += 4;
    end while (rd[0] === 1'b1 && n < 400);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task t_regs;
    apb(1'b0, CTRL, '0);
    chk(rd, 32'h0);
    apb(1'b0, 32'h0000_0100, '0);
    chk({rd[30:0], err}, 32'h1);
    eebusy <= 1'b1;
    apb(1'b1, CTRL, {26'h0, fsps_pkg::CMD_SIG});
    apb(1'b0, CTRL, '0);
    chk(rd, 32'h0);
    eebusy <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      {bhi, blo} <= i[1:0];
      repeat (5) @(posedge clk);
      chk(boot_start, bs[i]);
    end
    $display("register test done");
  endtask
  task t_sig;
    for (int i = 0; i < 4; i++) begin
      cmd(fsps_pkg::CMD_SIG, 1'b1, za[i]);
      chk({load_valid, load_data}, {1'b1, sx[i]});
      apb(1'b0, CTRL, '0);
      chk(rd, 32'h0);
    end
    apb(1'b1, CTRL, {26'h0, fsps_pkg::CMD_SIG});
    repeat (4) @(posedge clk);
    apb(1'b0, CTRL, '0);
    chk(rd, 32'h0);
    cpu.issue(1'b1, 16'h1235, 16'h0);
    w = 16'h1234 ^ 16'h5a3c;
    chk({load_valid, load_data}, {1'b1, w[15:8]});
    cmd(fsps_pkg::CMD_SIG, 1'b0, 16'h0000);
    chk({flash_cmd.erase, flash_cmd.write, flash_cmd.load}, 3'h0);
    repeat (4) @(posedge clk);
    $display("signature test done");
  endtask
  task t_lower;
    cmd(fsps_pkg::CMD_ERASE, 1'b0, 16'hdf00);
    chk({flash_cmd.erase, flash_cmd.page}, {1'b1, 8'hdf});
    chk({sec_busy, fetch_stall}, 2'b10);
    apb(1'b0, CTRL, '0);
    chk({rd[6], rd[0]}, 2'b11);
    wait_idle;
    chk(n >= OPC - 4 && n <= OPC + 12, 1'b1);
    cmd(fsps_pkg::CMD_LOAD, 1'b0, 16'hdf02);
    chk({flash_cmd.load, flash_cmd.word, flash_cmd.data},
        {1'b1, 7'h01, 16'hbeef});
    chk(sec_busy, 1'b0);
    cmd(fsps_pkg::CMD_REEN, 1'b0, 16'h0000);
    chk(flash_cmd.clear_buf, 1'b1);
    $display("lower section test done");
  endtask
  task t_lock;
    cmd(fsps_pkg::CMD_LOCK, 1'b0, 16'h0000);
    chk({flash_cmd.lock, sec_busy, fetch_stall}, 3'b100);
    apb(1'b0, fsps_pkg::STATUS_ADDR, '0);
    chk(rd, {13'h0, 2'b11, 15'h7e00, 2'b01});
    wait_idle;
    chk(n >= OPC - 4 && n <= OPC + 12, 1'b1);
    $display("lock test done");
  endtask
  task t_upper;
    cmd(fsps_pkg::CMD_WRITE, 1'b0, 16'he000);
    chk({flash_cmd.write, sec_busy, fetch_stall}, 3'b101);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    apb(1'b0, CTRL, '0);
    chk(rd[0], 1'b1);
    wait_idle;
    chk(rd[0], 1'b0);
    $display("upper section test done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs;
    t_sig;
    t_lower;
    t_lock;
    t_upper;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    stop_test;
  end
endmodule
`default_nettype wire
